// ==== design/sbp_defs.svh ====
// Notes on behaviour
// - Direction bit one: input, driver off
// - Direction bit zero: drive latch onto pin
// - Pin a3 input only, direction reads one
// - Six pins, own direction and latch bits
// - Port read gives pins; write sets latch
// - Latch read returns latch, not pins
// - Latch write acts like port write
// - Port write is read-modify-write into latch
// - Direction still controls analog pins
// - Analog-select pin reads zero digitally
// - Analog select leaves digital outputs alone
// - Steering never changes direction bits
// - Bit 7 puts serial rx on a1/a5
// - Bit 6 puts SPI out on a0/a4
// - Bit 5 takes slave select a3/a0
// - Bit 3 takes timer gate a4/a3
// - Bit 2 puts serial tx on a0/a4
// - Bit 1 puts PWM B on a0/a4
// - Bit 0 puts capture/PWM A a2/a5
// - Enabled peripheral takes over its pin
// - Highest priority output wins the pin
// - Pull-up off while pin drives out
`ifndef SBP_DEFS_SVH
`define SBP_DEFS_SVH

`define SBP_OFF_PIN_VALUE 8'h00
`define SBP_OFF_OUT_LATCH 8'h04
`define SBP_OFF_DIRECTION 8'h08
`define SBP_OFF_ANALOG_SEL 8'h0c
`define SBP_OFF_WEAK_PULLUP 8'h10
`define SBP_OFF_PIN_STEER 8'h14

`define SBP_RST_DIRECTION 6'h3f
`define SBP_RST_ANALOG_SEL 6'h17
`define SBP_RST_WEAK_PULLUP 6'h3f
`define SBP_RST_PIN_STEER 8'h00
`define SBP_RST_OUT_LATCH 6'h00

`define SBP_MASK_ANALOG_SEL 6'h17
`define SBP_MASK_OUT_LATCH 6'h37
`define SBP_MASK_PIN_STEER 8'hef
`define SBP_INPUT_ONLY_PIN 3

`define SBP_BIT_RX_STEER 7
`define SBP_BIT_SDO_STEER 6
`define SBP_BIT_SS_STEER 5
`define SBP_BIT_TGATE_STEER 3
`define SBP_BIT_TX_STEER 2
`define SBP_BIT_PWMB_STEER 1
`define SBP_BIT_CCP_STEER 0

`define SBP_RESP_OKAY 2'b00
`define SBP_RESP_SLVERR 2'b10

`endif

// ==== design/sbp_pkg.sv ====
package sbp_pkg;

  typedef enum logic [1:0] {
    SBP_CH_IDLE = 2'b01,
    SBP_CH_RESP = 2'b10
  } sbp_chan_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } sbp_wreq_s;

  typedef struct packed {
    logic ok;
    logic [31:0] data;
  } sbp_rans_s;

endpackage

// ==== design/sbp_axil_slave.sv ====
`timescale 1ns/100ps
`include "sbp_defs.svh"

module sbp_axil_slave (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // AXI4-Lite write
  input wire logic [7:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  // AXI4-Lite read
  input wire logic [7:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  // Register file side
  output logic wr_en_out,
  output sbp_pkg::sbp_wreq_s wr_req_out,
  input wire logic wr_ok_in,
  output logic rd_en_out,
  output logic [7:0] rd_addr_out,
  input wire sbp_pkg::sbp_rans_s rd_ans_in
);

  sbp_pkg::sbp_chan_e wstate, next_wstate, rstate, next_rstate;
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;

  // Address and data may arrive in either order; each is held until both are in
  always_comb begin
    next_wstate = wstate;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bresp = bresp_out;
    wr_en_out = 1'b0;
    if (awvalid_in && awready_out) begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr_in;
    end
    if (wvalid_in && wready_out) begin
      next_w_held = 1'b1;
      next_w_data = wdata_in;
      next_w_strb = wstrb_in;
    end
    case (wstate)
      sbp_pkg::SBP_CH_IDLE: begin
        if (aw_held && w_held) begin
          wr_en_out = 1'b1;
          next_bresp = wr_ok_in ? `SBP_RESP_OKAY : `SBP_RESP_SLVERR;
          next_aw_held = 1'b0;
          next_w_held = 1'b0;
          next_wstate = sbp_pkg::SBP_CH_RESP;
        end
      end
      sbp_pkg::SBP_CH_RESP: begin
        if (bready_in) begin
          next_wstate = sbp_pkg::SBP_CH_IDLE;
        end
      end
      default: next_wstate = sbp_pkg::SBP_CH_IDLE;
    endcase
  end

  assign wr_req_out = '{addr: aw_addr, data: w_data, strb: w_strb};

  always_comb begin
    next_rstate = rstate;
    next_rdata = rdata_out;
    next_rresp = rresp_out;
    rd_en_out = 1'b0;
    rd_addr_out = araddr_in;
    case (rstate)
      sbp_pkg::SBP_CH_IDLE: begin
        if (arvalid_in && arready_out) begin
          rd_en_out = 1'b1;
          next_rdata = rd_ans_in.data;
          next_rresp = rd_ans_in.ok ? `SBP_RESP_OKAY : `SBP_RESP_SLVERR;
          next_rstate = sbp_pkg::SBP_CH_RESP;
        end
      end
      sbp_pkg::SBP_CH_RESP: begin
        if (rready_in) begin
          next_rstate = sbp_pkg::SBP_CH_IDLE;
        end
      end
      default: next_rstate = sbp_pkg::SBP_CH_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      wstate <= sbp_pkg::SBP_CH_IDLE;
      rstate <= sbp_pkg::SBP_CH_IDLE;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      awready_out <= 1'b0;
      wready_out <= 1'b0;
      bvalid_out <= 1'b0;
      bresp_out <= 2'h0;
      arready_out <= 1'b0;
      rvalid_out <= 1'b0;
      rdata_out <= 32'h0000_0000;
      rresp_out <= 2'h0;
    end else begin
      wstate <= next_wstate;
      rstate <= next_rstate;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      awready_out <= !next_aw_held && (next_wstate == sbp_pkg::SBP_CH_IDLE);
      wready_out <= !next_w_held && (next_wstate == sbp_pkg::SBP_CH_IDLE);
      bvalid_out <= (next_wstate == sbp_pkg::SBP_CH_RESP);
      bresp_out <= next_bresp;
      arready_out <= (next_rstate == sbp_pkg::SBP_CH_IDLE);
      rvalid_out <= (next_rstate == sbp_pkg::SBP_CH_RESP);
      rdata_out <= next_rdata;
      rresp_out <= next_rresp;
    end
  end

endmodule

// ==== design/sbp_port.sv ====
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "sbp_defs.svh"

module sbp_port #(
  parameter int PINS = 6
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // AXI4-Lite write
  input wire logic [7:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  // AXI4-Lite read
  input wire logic [7:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  // Package pins
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe_out,
  output logic [PINS-1:0] pullup_en_out,
  // Peripheral outputs asking for a pin
  input wire logic serial_tx_clk_in,
  input wire logic serial_tx_clk_en_in,
  input wire logic serial_rx_data_in,
  input wire logic serial_rx_data_en_in,
  input wire logic spi_out_in,
  input wire logic spi_out_en_in,
  input wire logic pwm_b_out_in,
  input wire logic pwm_b_out_en_in,
  input wire logic capture_pwm_a_in,
  input wire logic capture_pwm_a_en_in,
  // Pin levels steered to peripherals
  output logic serial_rx_data_out,
  output logic serial_tx_clk_out,
  output logic slave_select_out,
  output logic timer_gate_in_out,
  output logic capture_pwm_a_out
);

  // Register file
  logic [PINS-1:0] direction_bits, next_direction_bits;
  logic [PINS-1:0] output_latch_reg, next_output_latch_reg;
  logic [PINS-1:0] analog_select_bits, next_analog_select_bits;
  logic [PINS-1:0] weak_pullup_bits, next_weak_pullup_bits;
  logic [7:0] pin_steering_select, next_pin_steering_select;

  // Pin sampling
  logic [PINS-1:0] pin_meta;
  logic [PINS-1:0] pin_sync;
  logic [PINS-1:0] digital_in;

  // Bus side
  logic wr_en;
  sbp_pkg::sbp_wreq_s wr_req;
  logic wr_ok;
  logic rd_en;
  logic [7:0] rd_addr;
  sbp_pkg::sbp_rans_s rd_ans;

  // Pin drive
  logic [PINS-1:0] next_pin_out, next_pin_oe;
  logic [PINS-1:0] next_pullup_en;
  logic next_rx_data;
  logic next_tx_clk;
  logic next_slave_select;
  logic next_timer_gate;
  logic next_capture;

  // Priority pick among up to three peripheral outputs, then the port latch;
  // en[2] is the highest rank. Result is {drive enable, level}.
  function automatic logic [1:0] sbp_pick(
    input logic [2:0] en,
    input logic [2:0] lvl,
    input logic gpio_oe,
    input logic gpio_lvl
  );
    logic [1:0] res;
    res = {gpio_oe, gpio_lvl};
    if (en[2]) begin
      res = {1'b1, lvl[2]};
    end else if (en[1]) begin
      res = {1'b1, lvl[1]};
    end else if (en[0]) begin
      res = {1'b1, lvl[0]};
    end
    return res;
  endfunction

  // Register read decode
  function automatic sbp_pkg::sbp_rans_s sbp_read(
    input logic [7:0] addr,
    input logic [PINS-1:0] pins,
    input logic [PINS-1:0] lat,
    input logic [PINS-1:0] dir,
    input logic [PINS-1:0] ana,
    input logic [PINS-1:0] wpu,
    input logic [7:0] steer
  );
    sbp_pkg::sbp_rans_s ans;
    ans.ok = 1'b1;
    ans.data = 32'h0000_0000;
    case ({addr[7:2], 2'b00})
      `SBP_OFF_PIN_VALUE: ans.data[PINS-1:0] = pins;
      `SBP_OFF_OUT_LATCH: ans.data[PINS-1:0] = lat & `SBP_MASK_OUT_LATCH;
      `SBP_OFF_DIRECTION: ans.data[PINS-1:0] = dir;
      `SBP_OFF_ANALOG_SEL: ans.data[PINS-1:0] = ana;
      `SBP_OFF_WEAK_PULLUP: ans.data[PINS-1:0] = wpu;
      `SBP_OFF_PIN_STEER: ans.data[7:0] = steer & `SBP_MASK_PIN_STEER;
      default: ans.ok = 1'b0;
    endcase
    return ans;
  endfunction

  // Two-way pin choice; a set select takes the first candidate
  function automatic logic sbp_steer(
    input logic sel,
    input logic when_set,
    input logic when_clear
  );
    return sel ? when_set : when_clear;
  endfunction

  // Six word offsets are mapped; anything else is refused
  function automatic logic sbp_mapped(input logic [7:0] addr);
    logic hit;
    case ({addr[7:2], 2'b00})
      `SBP_OFF_PIN_VALUE, `SBP_OFF_OUT_LATCH, `SBP_OFF_DIRECTION,
      `SBP_OFF_ANALOG_SEL, `SBP_OFF_WEAK_PULLUP, `SBP_OFF_PIN_STEER: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Slave owns the handshakes; this level owns the register map
  sbp_axil_slave u_bus (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .awaddr_in(awaddr_in),
    .awvalid_in(awvalid_in),
    .awready_out(awready_out),
    .wdata_in(wdata_in),
    .wstrb_in(wstrb_in),
    .wvalid_in(wvalid_in),
    .wready_out(wready_out),
    .bresp_out(bresp_out),
    .bvalid_out(bvalid_out),
    .bready_in(bready_in),
    .araddr_in(araddr_in),
    .arvalid_in(arvalid_in),
    .arready_out(arready_out),
    .rdata_out(rdata_out),
    .rresp_out(rresp_out),
    .rvalid_out(rvalid_out),
    .rready_in(rready_in),
    .wr_en_out(wr_en),
    .wr_req_out(wr_req),
    .wr_ok_in(wr_ok),
    .rd_en_out(rd_en),
    .rd_addr_out(rd_addr),
    .rd_ans_in(rd_ans)
  );

  // Pins come from outside the clock domain; two flops before any use
  // Both stages clear in reset, so pins read low at first
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // Analog pins have their digital input buffer off and read as zero
  assign digital_in = pin_sync & ~analog_select_bits;

  // Read answer is built from live state; the slave samples it on acceptance.
  // Zero between reads, so the decode only toggles when a read is taken.
  always_comb begin
    rd_ans = '0;
    if (rd_en) begin
      rd_ans = sbp_read(rd_addr, digital_in, output_latch_reg, direction_bits,
                        analog_select_bits, weak_pullup_bits, pin_steering_select);
    end
  end

  // Refused offsets answer with an error and change nothing
  assign wr_ok = sbp_mapped(wr_req.addr);

  // Register writes; only byte lane 0 carries register bits
  always_comb begin
    next_direction_bits = direction_bits;
    next_output_latch_reg = output_latch_reg;
    next_analog_select_bits = analog_select_bits;
    next_weak_pullup_bits = weak_pullup_bits;
    next_pin_steering_select = pin_steering_select;
    if (wr_en) begin
      case ({wr_req.addr[7:2], 2'b00})
        `SBP_OFF_PIN_VALUE, `SBP_OFF_OUT_LATCH: begin
          // Read-modify-write: pins read back, written lane merged, result latched.
          // An analog pin reads zero, so a lane-less write can clear its latch bit.
          next_output_latch_reg = (wr_req.strb[0] ? wr_req.data[PINS-1:0] : digital_in)
                                  & `SBP_MASK_OUT_LATCH;
        end
        `SBP_OFF_DIRECTION: begin
          if (wr_req.strb[0]) begin
            next_direction_bits = wr_req.data[PINS-1:0];
            // Input-only pin: no write can ever enable its driver
            next_direction_bits[`SBP_INPUT_ONLY_PIN] = 1'b1;
          end
        end
        `SBP_OFF_ANALOG_SEL: begin
          if (wr_req.strb[0]) begin
            // Pins without an analog path keep their select clear
            next_analog_select_bits = wr_req.data[PINS-1:0] & `SBP_MASK_ANALOG_SEL;
          end
        end
        `SBP_OFF_WEAK_PULLUP: begin
          if (wr_req.strb[0]) begin
            next_weak_pullup_bits = wr_req.data[PINS-1:0];
          end
        end
        `SBP_OFF_PIN_STEER: begin
          // Steering touches only its own register, never direction bits
          if (wr_req.strb[0]) begin
            next_pin_steering_select = wr_req.data[7:0] & `SBP_MASK_PIN_STEER;
          end
        end
        default: next_pin_steering_select = pin_steering_select;
      endcase
    end
  end

  // Reset leaves every pin a tri-stated input
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      direction_bits <= `SBP_RST_DIRECTION;
      output_latch_reg <= `SBP_RST_OUT_LATCH;
      analog_select_bits <= `SBP_RST_ANALOG_SEL;
      weak_pullup_bits <= `SBP_RST_WEAK_PULLUP;
      pin_steering_select <= `SBP_RST_PIN_STEER;
    end else begin
      direction_bits <= next_direction_bits;
      output_latch_reg <= next_output_latch_reg;
      analog_select_bits <= next_analog_select_bits;
      weak_pullup_bits <= next_weak_pullup_bits;
      pin_steering_select <= next_pin_steering_select;
    end
  end

  // Pin drive. Port drive follows the direction bit whatever the analog
  // select says; a peripheral enabled on its selected pin takes the pin over.
  always_comb begin
    logic [PINS-1:0] g_oe;
    logic [1:0] r0, r1, r2, r4, r5;
    g_oe = ~direction_bits;
    r0 = sbp_pick({serial_tx_clk_en_in && !pin_steering_select[`SBP_BIT_TX_STEER],
                   spi_out_en_in && !pin_steering_select[`SBP_BIT_SDO_STEER],
                   pwm_b_out_en_in && !pin_steering_select[`SBP_BIT_PWMB_STEER]},
                  {serial_tx_clk_in, spi_out_in, pwm_b_out_in},
                  g_oe[0], output_latch_reg[0]);
    r1 = sbp_pick({serial_rx_data_en_in && !pin_steering_select[`SBP_BIT_RX_STEER],
                   2'b00}, {serial_rx_data_in, 2'b00},
                  g_oe[1], output_latch_reg[1]);
    r2 = sbp_pick({capture_pwm_a_en_in && !pin_steering_select[`SBP_BIT_CCP_STEER],
                   2'b00}, {capture_pwm_a_in, 2'b00},
                  g_oe[2], output_latch_reg[2]);
    r4 = sbp_pick({serial_tx_clk_en_in && pin_steering_select[`SBP_BIT_TX_STEER],
                   spi_out_en_in && pin_steering_select[`SBP_BIT_SDO_STEER],
                   pwm_b_out_en_in && pin_steering_select[`SBP_BIT_PWMB_STEER]},
                  {serial_tx_clk_in, spi_out_in, pwm_b_out_in},
                  g_oe[4], output_latch_reg[4]);
    r5 = sbp_pick({serial_rx_data_en_in && pin_steering_select[`SBP_BIT_RX_STEER],
                   capture_pwm_a_en_in && pin_steering_select[`SBP_BIT_CCP_STEER],
                   1'b0}, {serial_rx_data_in, capture_pwm_a_in, 1'b0},
                  g_oe[5], output_latch_reg[5]);
    // Input-only pin never drives, whatever claims it
    next_pin_oe = {r5[1], r4[1], 1'b0, r2[1], r1[1], r0[1]};
    next_pin_out = {r5[0], r4[0], 1'b0, r2[0], r1[0], r0[0]};
    // Pull-up released on any driven pin, port or peripheral alike
    next_pullup_en = weak_pullup_bits & ~next_pin_oe;
  end

  // Inputs to peripherals follow the steering bits
  always_comb begin
    next_rx_data = sbp_steer(pin_steering_select[`SBP_BIT_RX_STEER],
      digital_in[5], digital_in[1]);
    next_tx_clk = sbp_steer(pin_steering_select[`SBP_BIT_TX_STEER],
      digital_in[4], digital_in[0]);
    next_slave_select = sbp_steer(pin_steering_select[`SBP_BIT_SS_STEER],
      digital_in[0], digital_in[3]);
    next_timer_gate = sbp_steer(pin_steering_select[`SBP_BIT_TGATE_STEER],
      digital_in[3], digital_in[4]);
    next_capture = sbp_steer(pin_steering_select[`SBP_BIT_CCP_STEER],
      digital_in[5], digital_in[2]);
  end

  // Registered drive keeps decode glitches off the pads
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      pin_out <= '0;
      pin_oe_out <= '0;
      pullup_en_out <= '0;
    end else begin
      pin_out <= next_pin_out;
      pin_oe_out <= next_pin_oe;
      pullup_en_out <= next_pullup_en;
    end
  end

  // Peripheral inputs lag the pins by three edges in all
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      serial_rx_data_out <= 1'b0;
      serial_tx_clk_out <= 1'b0;
      slave_select_out <= 1'b0;
      timer_gate_in_out <= 1'b0;
      capture_pwm_a_out <= 1'b0;
    end else begin
      serial_rx_data_out <= next_rx_data;
      serial_tx_clk_out <= next_tx_clk;
      slave_select_out <= next_slave_select;
      timer_gate_in_out <= next_timer_gate;
      capture_pwm_a_out <= next_capture;
    end
  end

endmodule

// ==== verif/sbp_pin_model.sv ====
`timescale 1ns/100ps

module sbp_pin_model #(
  parameter int PINS = 6
) (
  // Clock
  input wire logic clk_in,
  // Port side of each pin
  input wire logic [PINS-1:0] pin_out_in,
  input wire logic [PINS-1:0] pin_oe_in,
  input wire logic [PINS-1:0] pullup_in,
  // Outside drivers
  input wire logic [PINS-1:0] ext_lvl_in,
  input wire logic [PINS-1:0] ext_en_in,
  // Resolved wire
  output logic [PINS-1:0] wire_out
);
  logic [PINS-1:0] churn = '0;

  // A floating pin without pull-up never holds a value the bench could rely on
  always @(posedge clk_in) begin
    churn <= ~churn;
  end

  assign wire_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ext_en_in & ext_lvl_in) |
    (~pin_oe_in & ~ext_en_in & (pullup_in | churn));
endmodule

// ==== verif/sbp_port_asserts.sv ====
`timescale 1ns/100ps

module sbp_port_asserts #(
  parameter int PINS = 6
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Bus handshakes
  input wire logic awvalid_in,
  input wire logic awready_out,
  input wire logic wvalid_in,
  input wire logic wready_out,
  input wire logic bvalid_out,
  input wire logic arvalid_in,
  input wire logic arready_out,
  input wire logic rvalid_out,
  input wire logic rready_in,
  input wire logic [31:0] rdata_out,
  input wire logic [1:0] rresp_out,
  // Pins and claims
  input wire logic [PINS-1:0] pin_oe_out,
  input wire logic [PINS-1:0] pullup_en_out,
  input wire logic serial_tx_clk_en_in,
  input wire logic capture_pwm_a_en_in
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence wr_taken_s;
    awvalid_in && awready_out && wvalid_in && wready_out;
  endsequence
  sequence wr_answer_s;
    !bvalid_out ##1 bvalid_out;
  endsequence

  a3_no_drive_a: assert property (!pin_oe_out[3])
    else $error("input only pin driven");
  pullup_off_a: assert property ((pullup_en_out & pin_oe_out) == '0)
    else $error("pull-up on while driving");
  tx_claims_pin_a: assert property ($past(rst_b_in && serial_tx_clk_en_in) |->
    (pin_oe_out[0] || pin_oe_out[4])) else $error("serial tx claim not driven");
  ccp_claims_pin_a: assert property ($past(rst_b_in && capture_pwm_a_en_in) |->
    (pin_oe_out[2] || pin_oe_out[5])) else $error("capture claim not driven");
  write_answer_a: assert property (wr_taken_s |=> wr_answer_s)
    else $error("write answer late or early");
  ready_low_a: assert property (bvalid_out |-> !awready_out && !wready_out)
    else $error("ready up during write answer");
  read_answer_a: assert property (arvalid_in && arready_out |=> rvalid_out)
    else $error("read answer late");
  read_hold_a: assert property (rvalid_out && !rready_in |=>
    rvalid_out && $stable(rdata_out)) else $error("read data not held");
  read_err_zero_a: assert property (rvalid_out && rresp_out != 2'b00 |-> rdata_out == 32'h0)
    else $error("refused read carries data");
  read_no_ar_a: assert property (rvalid_out |-> !arready_out)
    else $error("address ready during read answer");
endmodule

bind sbp_port sbp_port_asserts #(.PINS(PINS)) i_chk (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .awvalid_in(awvalid_in), .awready_out(awready_out),
  .wvalid_in(wvalid_in), .wready_out(wready_out), .bvalid_out(bvalid_out),
  .arvalid_in(arvalid_in), .arready_out(arready_out), .rvalid_out(rvalid_out),
  .rready_in(rready_in), .rdata_out(rdata_out), .rresp_out(rresp_out),
  .pin_oe_out(pin_oe_out), .pullup_en_out(pullup_en_out),
  .serial_tx_clk_en_in(serial_tx_clk_en_in), .capture_pwm_a_en_in(capture_pwm_a_en_in)
);

// ==== verif/six_bit_port_with_pin_steering_tb.sv ====
`timescale 1ns/100ps
`include "sbp_defs.svh"
`define TB_EQ(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module six_bit_port_with_pin_steering_tb;
  localparam logic [7:0] PV = `SBP_OFF_PIN_VALUE;
  localparam logic [7:0] LAT = `SBP_OFF_OUT_LATCH;
  localparam logic [7:0] DIR = `SBP_OFF_DIRECTION;
  localparam logic [7:0] ANA = `SBP_OFF_ANALOG_SEL;
  localparam logic [7:0] STR = `SBP_OFF_PIN_STEER;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rd;
  logic [3:0] wstrb = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [5:0] pin_lvl, pin_drv, pin_oe, pull_en, v, e;
  logic [5:0] ext_lvl = '0;
  logic [4:0] p_lvl = '0, p_en = '0, p_in;
  logic [7:0] s;
  int bad_count = 0;
  int total_checks = 0;

  always #12.5 clk_in = ~clk_in;

  sbp_port #(.PINS(6)) i_dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .awaddr_in(awaddr), .awvalid_in(awvalid),
    .awready_out(awready), .wdata_in(wdata), .wstrb_in(wstrb), .wvalid_in(wvalid),
    .wready_out(wready), .bresp_out(bresp), .bvalid_out(bvalid), .bready_in(bready),
    .araddr_in(araddr), .arvalid_in(arvalid), .arready_out(arready), .rdata_out(rdata),
    .rresp_out(rresp), .rvalid_out(rvalid), .rready_in(rready), .pin_in(pin_lvl),
    .pin_out(pin_drv), .pin_oe_out(pin_oe), .pullup_en_out(pull_en),
    .serial_tx_clk_in(p_lvl[0]), .serial_tx_clk_en_in(p_en[0]),
    .serial_rx_data_in(p_lvl[1]), .serial_rx_data_en_in(p_en[1]),
    .spi_out_in(p_lvl[2]), .spi_out_en_in(p_en[2]), .pwm_b_out_in(p_lvl[3]),
    .pwm_b_out_en_in(p_en[3]), .capture_pwm_a_in(p_lvl[4]), .capture_pwm_a_en_in(p_en[4]),
    .serial_rx_data_out(p_in[4]), .serial_tx_clk_out(p_in[3]), .slave_select_out(p_in[2]),
    .timer_gate_in_out(p_in[1]), .capture_pwm_a_out(p_in[0])
  );

  sbp_pin_model #(.PINS(6)) i_pins (
    .clk_in(clk_in), .pin_out_in(pin_drv), .pin_oe_in(pin_oe), .pullup_in(pull_en),
    .ext_lvl_in(ext_lvl), .ext_en_in(6'h3f), .wire_out(pin_lvl)
  );

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic timed_out();
    bad_count++;
    $display("Wait limit used up at %0t", $time);
    tally_and_finish();
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st);
    int n;
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_in);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (n == 40) timed_out();
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, 4'h1);
    `TB_EQ(resp, `SBP_RESP_OKAY)
  endtask

  // Read ready comes one cycle late so the held answer is exercised
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] xr);
    int n;
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_in);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1 && rready === 1'b1) break;
      if (rvalid === 1'b1) rready <= 1'b1;
    end
    if (n == 40) timed_out();
    rd = rdata;
    `TB_EQ(rresp, xr)
    rready <= 1'b0;
    `TB_EQ(rd, x)
  endtask

  function automatic int pin_of(int k, logic [7:0] st);
    case (k)
      0: return st[2] ? 4 : 0;
      1: return st[7] ? 5 : 1;
      2: return st[6] ? 4 : 0;
      3: return st[1] ? 4 : 0;
      default: return st[0] ? 5 : 2;
    endcase
  endfunction

  function automatic logic [4:0] steer_in(logic [5:0] lv, logic [7:0] st);
    return {lv[st[7] ? 5 : 1], lv[st[2] ? 4 : 0], lv[st[5] ? 0 : 3], lv[st[3] ? 3 : 4],
            lv[st[0] ? 5 : 2]};
  endfunction

  initial begin
    void'($urandom(28495));
    repeat (16) @(posedge clk_in);
    rst_b_in <= 1'b1;
    chk_rd(DIR, 32'h3f, 2'b00);
    chk_rd(LAT, 32'h00, 2'b00);
    chk_rd(ANA, 32'h17, 2'b00);
    chk_rd(STR, 32'h00, 2'b00);
    chk_rd(8'h18, 32'h00, 2'b10);
    wr(8'h18, 32'hff, 4'h1);
    `TB_EQ(resp, `SBP_RESP_SLVERR)
    ext_lvl <= 6'($urandom);
    wr_ok(ANA, 32'h0);
    wr_ok(DIR, 32'h0);
    chk_rd(DIR, 32'h08, 2'b00);
    for (int i = 0; i < 4; i++) begin
      v = 6'($urandom);
      wr_ok(i[0] ? PV : LAT, 32'(v));
      chk_rd(LAT, 32'(v & 6'h37), 2'b00);
      wt(2);
      `TB_EQ(pin_oe, 6'h37)
      `TB_EQ(pin_drv & 6'h37, v & 6'h37)
      `TB_EQ(pull_en, 6'h08)
      chk_rd(PV, 32'((v & 6'h37) | (ext_lvl & 6'h08)), 2'b00);
    end
    wr_ok(DIR, 32'h3f);
    e = 6'($urandom);
    ext_lvl <= e;
    wt(4);
    `TB_EQ(pin_oe, 6'h00)
    chk_rd(PV, 32'(e), 2'b00);
    chk_rd(LAT, 32'(v & 6'h37), 2'b00);
    wr(LAT, 32'h0, 4'h0);
    chk_rd(LAT, 32'(e & 6'h37), 2'b00);
    wr_ok(ANA, 32'h3f);
    chk_rd(ANA, 32'h17, 2'b00);
    chk_rd(PV, 32'(e & 6'h28), 2'b00);
    wr_ok(LAT, 32'(v));
    wr_ok(DIR, 32'h0);
    wt(2);
    `TB_EQ(pin_oe, 6'h37)
    `TB_EQ(pin_drv & 6'h37, v & 6'h37)
    wr_ok(DIR, 32'h3f);
    wr_ok(ANA, 32'h0);
    for (int i = 0; i < 4; i++) begin
      s = (i == 0) ? 8'h00 : (i == 1) ? 8'hef : 8'($urandom);
      wr_ok(STR, 32'(s));
      p_en <= '0;
      s = s & `SBP_MASK_PIN_STEER;
      chk_rd(STR, 32'(s), 2'b00);
      chk_rd(DIR, 32'h3f, 2'b00);
      e = 6'($urandom);
      ext_lvl <= e;
      wt(4);
      `TB_EQ(p_in, steer_in(e, s))
      for (int k = 0; k < 5; k++) begin
        @(posedge clk_in);
        p_en <= 5'(1 << k);
        p_lvl <= 5'($urandom);
        wt(2);
        `TB_EQ(pin_oe, 6'(1 << pin_of(k, s)))
        `TB_EQ(pin_drv[pin_of(k, s)], p_lvl[k])
      end
    end
    wr_ok(STR, 32'h0);
    p_en <= 5'b01101;
    p_lvl <= 5'b01100;
    wt(2);
    `TB_EQ(pin_drv[0], 1'b0)
    @(posedge clk_in);
    p_en <= 5'b01100;
    p_lvl <= 5'b00100;
    wt(2);
    `TB_EQ(pin_drv[0], 1'b1)
    tally_and_finish();
  end

  initial begin
    #2000000;
    timed_out();
  end
endmodule
